// ---- rtl/sfcs_params.svh ----
// Purpose: constants for the serial flash command sequencer
// Assumes: one 20 MHz clock, SPI mode 0, single data lane
// Notes: flash status byte layout and opcodes
// Behaviour
// - Status bit 0 means flash busy
// - Status bit 1 is write latch flag
// - Bits 6:2 zero remove block protection
// - Status bit 7 is status lock bit
// - Status accesses are one byte only
// - Always run protection disable at boot
// - Boot: unlock, poll latch, write status zero
// - Unlock and poll latch before program/erase
// - Never read signature; no protocol adaptation
// - Fast read: 0x0B, address, dummy, data
// - Status read 0x05, write 0x01, unlock 0x06
// - Program 0x02, sector erase 0x20, chip 0xC7
// - Hold and write protect pins left undriven
// - SPI clock is reference divided by 2*(N/2+1), N 5..127
// - Boot load only from select zero flash
// - Init flag high during auto-init, low after
`ifndef SFCS_PARAMS_SVH
`define SFCS_PARAMS_SVH
`define SFCS_BUSY_BIT 0
`define SFCS_LATCH_BIT 1
`define SFCS_PROT_HI 6
`define SFCS_PROT_LO 2
`define SFCS_LOCK_BIT 7
`define SFCS_OP_FAST_READ 8'h0b
`define SFCS_OP_STATUS_READ 8'h05
`define SFCS_OP_STATUS_WRITE 8'h01
`define SFCS_OP_UNLOCK 8'h06
`define SFCS_OP_PAGE_PROG 8'h02
`define SFCS_OP_SECTOR_ERASE 8'h20
`define SFCS_OP_CHIP_ERASE 8'hc7
`define SFCS_STATUS_CLEAR 8'h00
`define SFCS_DIV_MIN 7'h05
`define SFCS_DIV_MAX 7'h7f
`define SFCS_DIV_RESET 7'h05
`endif

// ---- rtl/sfcs_pkg.sv ----
// Purpose: types of the serial flash command sequencer
// Assumes: constants come from sfcs_params.svh
// Notes: none
package sfcs_pkg;
  typedef enum logic [2:0] {
    SFCS_CMD_READ = 3'h0,
    SFCS_CMD_PROG = 3'h1,
    SFCS_CMD_SECTOR = 3'h2,
    SFCS_CMD_CHIP = 3'h3,
    SFCS_CMD_STATUS = 3'h4
  } sfcs_cmd_t;

  typedef struct packed {
    logic valid;
    sfcs_cmd_t cmd;
    logic [23:0] addr;
    logic [8:0] len;
  } sfcs_req_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs0_n;
    logic cs1_n;
  } sfcs_spi_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic tick_d;
  } sfcs_shift_st_t;
endpackage

// ---- rtl/sfcs_shifter.sv ----
// Purpose: one-byte mode 0 shifter with clock divider
// Assumes: miso already synchronised
// Notes: one byte per start, MSB first
`timescale 1ns/10ps
`include "sfcs_params.svh"
module sfcs_shifter
  import sfcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] div_n,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic done,
  output logic [7:0] rx_byte
);
  typedef struct packed {
    logic [6:0] cnt;
    logic busy;
    logic phase;
    logic [2:0] bit_i;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sclk;
    logic done;
  } sfcs_sh_t;
  sfcs_sh_t s_reg, s_next;
  logic [6:0] half;
  logic [6:0] n_eff;
  always_comb begin
    // Clamp N into its legal span
    n_eff = (div_n < `SFCS_DIV_MIN) ? `SFCS_DIV_MIN : div_n;
    half = n_eff >> 1;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.busy) begin
      if (start) begin
        s_next.busy = 1'b1;
        s_next.tx = tx_byte;
        s_next.bit_i = 3'h7;
        s_next.cnt = 7'h00;
        s_next.phase = 1'b0;
      end
    end else if (s_reg.cnt >= half) begin
      s_next.cnt = 7'h00;
      if (!s_reg.phase) begin
        s_next.sclk = 1'b1;
        s_next.phase = 1'b1;
      end else begin
        // Sample at the end of the high phase: pin flop and synchroniser lag
        s_next.rx = {s_reg.rx[6:0], miso};
        s_next.sclk = 1'b0;
        s_next.phase = 1'b0;
        if (s_reg.bit_i == 3'h0) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.bit_i = s_reg.bit_i - 3'h1;
          s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
      end
    end else begin
      s_next.cnt = s_reg.cnt + 7'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign sclk = s_reg.sclk;
  assign mosi = s_reg.tx[7];
  assign done = s_reg.done;
  assign rx_byte = s_reg.rx;
endmodule

// ---- rtl/sfcs_top.sv ----
// Purpose: serial flash command sequencer
// Assumes: flash on select zero; board pulls hold and protect high
// Notes: byte data handshake per data byte
`timescale 1ns/10ps
`include "sfcs_params.svh"
module sfcs_top
  import sfcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] div_n,
  input wire sfcs_req_t req,
  input wire logic [7:0] wr_data,
  input wire logic flash_miso,
  output logic req_ready,
  output logic data_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] status_out,
  output logic init_busy,
  output logic sclk,
  output logic mosi,
  output logic flash_select_zero_n,
  output logic flash_select_one_n
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    ST_BOOT = 4'h0,
    ST_IDLE = 4'h1,
    ST_UNLOCK = 4'h2,
    ST_GAP = 4'h3,
    ST_POLL = 4'h4,
    ST_OP = 4'h5,
    ST_ADDR = 4'h6,
    ST_DUMMY = 4'h7,
    ST_DATA = 4'h8,
    ST_WSTAT = 4'h9,
    ST_BUSYPOLL = 4'ha,
    ST_READ_STAT = 4'hb
  } sfcs_state_t;

  typedef struct packed {
    sfcs_state_t st;
    logic boot;
    logic gap_to_cmd;
    logic poll_latch;
    logic issued;
    logic [1:0] abyte;
    logic [8:0] left;
    sfcs_cmd_t cmd;
    logic [23:0] addr;
    logic [1:0] sync;
    sfcs_spi_t spi;
    logic ready;
    logic take;
    logic [7:0] rd;
    logic rvalid;
    logic [7:0] status;
    logic init;
  } sfcs_all_t;
  sfcs_all_t s_reg, s_next;

  logic sh_start;
  logic [7:0] sh_tx;
  logic sh_sclk;
  logic sh_mosi;
  logic sh_done;
  logic [7:0] sh_rx;

  sfcs_shifter u_shift (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .div_n(div_n),
    .start(sh_start),
    .tx_byte(sh_tx),
    .miso(s_reg.sync[1]),
    .sclk(sh_sclk),
    .mosi(sh_mosi),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  function automatic logic [7:0] op_of(input sfcs_cmd_t c);
    case (c)
      SFCS_CMD_READ: op_of = `SFCS_OP_FAST_READ;
      SFCS_CMD_PROG: op_of = `SFCS_OP_PAGE_PROG;
      SFCS_CMD_SECTOR: op_of = `SFCS_OP_SECTOR_ERASE;
      SFCS_CMD_CHIP: op_of = `SFCS_OP_CHIP_ERASE;
      default: op_of = `SFCS_OP_STATUS_READ;
    endcase
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[0], flash_miso};
    s_next.take = 1'b0;
    s_next.rvalid = 1'b0;
    s_next.spi.sclk = sh_sclk;
    s_next.spi.mosi = sh_mosi;
    s_next.spi.cs1_n = 1'b1;
    sh_start = 1'b0;
    sh_tx = 8'h00;
    case (s_reg.st)
      ST_BOOT: begin
        // Protection assumed on at every boot
        s_next.boot = 1'b1;
        s_next.st = ST_UNLOCK;
      end
      ST_IDLE: begin
        s_next.init = 1'b0;
        s_next.spi.cs0_n = 1'b1;
        if (req.valid && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.cmd = req.cmd;
          s_next.addr = req.addr;
          s_next.left = req.len;
          s_next.issued = 1'b0;
          if (req.cmd == SFCS_CMD_READ || req.cmd == SFCS_CMD_STATUS) begin
            s_next.st = ST_OP;
          end else begin
            s_next.st = ST_UNLOCK;
          end
        end else begin
          s_next.ready = 1'b1;
        end
      end
      ST_UNLOCK: begin
        s_next.spi.cs0_n = 1'b0;
        sh_tx = `SFCS_OP_UNLOCK;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.poll_latch = 1'b1;
          s_next.st = ST_GAP;
        end
      end
      ST_GAP: begin
        // Deselect one byte slot between commands
        s_next.spi.cs0_n = 1'b1;
        sh_tx = 8'hff;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.abyte = 2'h0;
          s_next.st = ST_POLL;
          if (s_reg.gap_to_cmd) begin
            // Latch seen: the guarded command gets a frame of its own
            s_next.gap_to_cmd = 1'b0;
            s_next.st = s_reg.boot ? ST_WSTAT : ST_OP;
          end
        end
      end
      ST_POLL: begin
        s_next.spi.cs0_n = 1'b0;
        sh_tx = (s_reg.abyte == 2'h0) ? `SFCS_OP_STATUS_READ : 8'h00;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.abyte = 2'h1;
          if (s_reg.abyte == 2'h1) begin
            s_next.status = sh_rx;
            s_next.abyte = 2'h0;
            s_next.st = ST_GAP;
            if (s_reg.poll_latch && sh_rx[`SFCS_LATCH_BIT]) begin
              s_next.poll_latch = 1'b0;
              s_next.gap_to_cmd = 1'b1;
            end else if (!s_reg.poll_latch && !sh_rx[`SFCS_BUSY_BIT]) begin
              s_next.st = ST_IDLE;
              s_next.boot = 1'b0;
              s_next.spi.cs0_n = 1'b1;
            end
          end
        end
      end
      ST_WSTAT: begin
        // Zero clears protection and lock bits together
        s_next.spi.cs0_n = 1'b0;
        sh_tx = (s_reg.abyte == 2'h0) ? `SFCS_OP_STATUS_WRITE : `SFCS_STATUS_CLEAR;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.abyte = s_reg.abyte + 2'h1;
          if (s_reg.abyte == 2'h1) begin
            s_next.st = ST_GAP;
          end
        end
      end
      ST_OP: begin
        s_next.spi.cs0_n = 1'b0;
        sh_tx = op_of(s_reg.cmd);
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.abyte = 2'h0;
          case (s_reg.cmd)
            SFCS_CMD_CHIP: s_next.st = ST_GAP;
            SFCS_CMD_STATUS: s_next.st = ST_READ_STAT;
            default: s_next.st = ST_ADDR;
          endcase
        end
      end
      ST_ADDR: begin
        sh_tx = s_reg.addr[23:16];
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.addr = {s_reg.addr[15:0], 8'h00};
          s_next.abyte = s_reg.abyte + 2'h1;
          if (s_reg.abyte == 2'h2) begin
            case (s_reg.cmd)
              SFCS_CMD_READ: s_next.st = ST_DUMMY;
              SFCS_CMD_PROG: begin
                s_next.st = ST_DATA;
                s_next.take = 1'b1;
              end
              default: s_next.st = ST_GAP;
            endcase
          end
        end
      end
      ST_DUMMY: begin
        sh_tx = 8'h00;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.st = ST_DATA;
        end
      end
      ST_DATA: begin
        sh_tx = wr_data;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.rd = sh_rx;
          s_next.rvalid = (s_reg.cmd == SFCS_CMD_READ);
          s_next.left = s_reg.left - 9'h001;
          if (s_reg.left <= 9'h001) begin
            s_next.spi.cs0_n = 1'b1;
            s_next.st = (s_reg.cmd == SFCS_CMD_READ) ? ST_IDLE : ST_GAP;
          end else begin
            s_next.take = (s_reg.cmd == SFCS_CMD_PROG);
          end
        end
      end
      ST_READ_STAT: begin
        sh_tx = 8'h00;
        sh_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (sh_done) begin
          s_next.issued = 1'b0;
          s_next.status = sh_rx;
          s_next.spi.cs0_n = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= ST_BOOT;
      s_reg.spi.cs0_n <= 1'b1;
      s_reg.spi.cs1_n <= 1'b1;
      s_reg.init <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Hold and write protect have no pins here
  assign req_ready = s_reg.ready;
  assign data_take = s_reg.take;
  assign rd_data = s_reg.rd;
  assign rd_valid = s_reg.rvalid;
  assign status_out = s_reg.status;
  assign init_busy = s_reg.init;
  assign sclk = s_reg.spi.sclk;
  assign mosi = s_reg.spi.mosi;
  assign flash_select_zero_n = s_reg.spi.cs0_n;
  assign flash_select_one_n = s_reg.spi.cs1_n;

  // ****************************************
  // Checks
  // ****************************************
  boot_init_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_reg.st != ST_IDLE && s_reg.boot) |-> init_busy)
    else $error("init flag dropped during boot");
  one_select_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    flash_select_one_n)
    else $error("second select driven");
  latch_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(s_reg.st == ST_OP) && s_reg.cmd != SFCS_CMD_READ && s_reg.cmd != SFCS_CMD_STATUS)
      |-> $past(s_reg.status[`SFCS_LATCH_BIT]) || s_reg.status[`SFCS_LATCH_BIT])
    else $error("program or erase without latch");
  boot_wstat_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_reg.st == ST_WSTAT) |-> s_reg.status[`SFCS_LATCH_BIT])
    else $error("status write before latch set");
  busy_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(s_reg.st == ST_IDLE) && !$past(s_reg.st == ST_DATA)
      && !$past(s_reg.st == ST_READ_STAT)) |-> !s_reg.status[`SFCS_BUSY_BIT])
    else $error("idle while flash busy");
  unlock_op_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_reg.st == ST_UNLOCK && sh_start) |-> sh_tx == `SFCS_OP_UNLOCK)
    else $error("bad unlock opcode");
  read_op_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_reg.st == ST_OP && sh_start && s_reg.cmd == SFCS_CMD_READ)
      |-> sh_tx == `SFCS_OP_FAST_READ)
    else $error("bad fast read opcode");
  idle_desel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s_reg.st == ST_IDLE) |=> ##1 flash_select_zero_n || s_reg.st != ST_IDLE)
    else $error("select held in idle");
endmodule

// ---- bench/sfcs_flash_model.sv ----
// Purpose: behavioural serial flash for the sequencer bench
// Assumes: SPI mode 0, one status byte, hold and protect pins pulled high
// Notes: latch shows one poll late, busy lasts three polls
`timescale 1ns/10ps
module sfcs_flash_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  output logic miso
);
  // ****
  // Frame decoder
  // ****
  logic [7:0] mem [int];
  logic [7:0] ops [$];
  logic [7:0] stat = 8'h1c;
  logic [7:0] sh, op, ob;
  logic [23:0] addr;
  int bits = 0;
  int nb = 0;
  int busy = 0;
  int viol = 0;
  int wel_wait = 0;
  initial miso = 1'b0;
  always @(negedge cs_n) begin
    bits = 0;
    nb = 0;
  end
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    bits++;
    if (bits % 8 == 0) begin
      if (nb == 0) begin
        op = sh;
        ops.push_back(op);
        if (busy != 0 && op != 8'h05) viol++;
        if (op inside {8'h02, 8'h20, 8'hc7} && !stat[1]) viol++;
        if (!(op inside {8'h0b, 8'h05, 8'h01, 8'h06, 8'h02, 8'h20, 8'hc7})) viol++;
      end else if (nb <= 3) addr = {addr[15:0], sh};
      else if (op == 8'h02) begin
        mem[addr] = sh;
        addr[7:0] = addr[7:0] + 8'h01;
      end
      if (op == 8'h01 && nb == 1) stat[7:2] = sh[7:2];
      if (op == 8'h01 && nb > 1) viol++;
      if (op == 8'h0b && nb >= 4) begin
        ob = mem.exists(addr) ? mem[addr] : 8'hff;
        addr = addr + 24'h000001;
      end else ob = stat;
      nb++;
    end
  end
  always @(negedge sclk) if (!cs_n) miso <= ob[7 - (bits % 8)];
  always @(posedge cs_n) begin
    miso <= ~miso;
    if (op == 8'h05 && nb > 1) begin
      if (busy > 0) busy--;
      if (wel_wait != 0) stat[1] = 1'b1;
      wel_wait = 0;
    end
    if (nb >= 1) case (op)
      8'h06: wel_wait = 1;
      8'h01, 8'h02, 8'h20, 8'hc7: begin
        stat[1] = 1'b0;
        busy = 3;
      end
      default: ;
    endcase
    if (op == 8'h20 && nb == 4) foreach (mem[k]) if (k[23:12] == addr[23:12]) mem[k] = 8'hff;
    if (op == 8'hc7 && nb == 1) mem.delete();
    stat[0] = busy != 0;
  end
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the flash command sequencer
// Assumes: flash model on select zero, divider at its minimum
// Notes: design inputs change on the falling edge
`timescale 1ns/10ps
module tb;
  import sfcs_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  sfcs_req_t req = '0;
  logic [7:0] wr_data = 8'ha5;
  logic [7:0] rd_data, status_out;
  logic flash_miso, req_ready, data_take, rd_valid, init_busy, sclk, mosi, sel0_n, sel1_n;
  logic [7:0] pdata [4] = '{8'ha5, 8'h3c, 8'h00, 8'h81};
  logic [7:0] rq [$];
  int pidx = 0;
  int errors = 0;
  int n_checks = 0;
  int sel1_low = 0;
  always #25 ref_clk = ~ref_clk;
  sfcs_top sfcs_top_inst (.ref_clk(ref_clk), .rstn(rstn), .div_n(7'h05), .req(req),
    .wr_data(wr_data), .flash_miso(flash_miso), .req_ready(req_ready), .data_take(data_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .status_out(status_out), .init_busy(init_busy),
    .sclk(sclk), .mosi(mosi), .flash_select_zero_n(sel0_n), .flash_select_one_n(sel1_n));
  sfcs_flash_model sfcs_flash_model_inst (.sclk(sclk), .mosi(mosi), .cs_n(sel0_n),
    .miso(flash_miso));
  // ****
  // Monitors and tasks
  // ****
  always @(posedge ref_clk) begin
    if (data_take === 1'b1) pidx <= pidx + 1;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (rstn && sel1_n !== 1'b1) sel1_low++;
  end
  always @(negedge ref_clk) wr_data <= pdata[pidx % 4];
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 20000 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    chk(req_ready, 1'b1);
  endtask
  task automatic run(input sfcs_cmd_t c, input logic [23:0] a, input logic [8:0] n);
    wait_ready();
    rq.delete();
    sfcs_flash_model_inst.ops.delete();
    pidx = 0;
    req = '{1'b1, c, a, n};
    @(negedge ref_clk);
    req.valid = 1'b0;
    chk(req_ready, 1'b0);
    wait_ready();
  endtask
  // Runs of status polls count as one entry
  task automatic chk_ops(input logic [31:0] e, input int n);
    logic [7:0] q [$];
    foreach (sfcs_flash_model_inst.ops[i])
      if (!(q.size() > 0 && q[$] == 8'h05 && sfcs_flash_model_inst.ops[i] == 8'h05))
        q.push_back(sfcs_flash_model_inst.ops[i]);
    chk(q.size(), n);
    for (int i = 0; i < n; i++) chk(q[i], e[8*(n-1-i) +: 8]);
  endtask
  task automatic chk_rd(input logic [31:0] e, input int n);
    chk(rq.size(), n);
    for (int i = 0; i < n; i++) chk(rq[i], e[8*(n-1-i) +: 8]);
  endtask
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    chk(init_busy, 1'b1);
    wait_ready();
    chk(init_busy, 1'b0);
    chk_ops(32'h06050105, 4);
    chk(sfcs_flash_model_inst.stat, 8'h00);
    run(SFCS_CMD_STATUS, 24'h000000, 9'h000);
    chk_ops(32'h00000005, 1);
    chk(status_out, 8'h00);
    run(SFCS_CMD_PROG, 24'h012ffe, 9'h002);
    chk_ops(32'h06050205, 4);
    run(SFCS_CMD_PROG, 24'h013000, 9'h002);
    run(SFCS_CMD_READ, 24'h012ffe, 9'h004);
    chk_ops(32'h0000000b, 1);
    chk_rd(32'ha53ca53c, 4);
    run(SFCS_CMD_SECTOR, 24'h012abc, 9'h000);
    chk_ops(32'h06052005, 4);
    run(SFCS_CMD_READ, 24'h012ffe, 9'h004);
    chk_rd(32'hffffa53c, 4);
    run(SFCS_CMD_CHIP, 24'h000000, 9'h000);
    chk_ops(32'h0605c705, 4);
    run(SFCS_CMD_READ, 24'h013000, 9'h000);
    chk_rd(32'h000000ff, 1);
    chk(sfcs_flash_model_inst.viol, 0);
    chk(sel1_low, 0);
    print_verdict();
  end
  initial begin
    #(50 * 90000);
    errors++;
    print_verdict();
  end
endmodule
